//--- src/svp_protect.sv
/*
  Supply voltage protection: under/overvoltage, unbalance, phase loss,
  phase sequence and power factor deviation with trip, warning and
  start inhibit. Settings sit on a word-addressed register port.
  Assumes measurements and motor state are synchronous to clk_sys.
*/
// What this block does
// - All voltage protections stay inactive without the voltage sensing option.
// - Every protection has a trip enable bit; all but phase loss and sequence also have a warning enable bit.
// - Enabled trip-mode fault detected while running trips the motor.
// - Trip-mode fault condition blocks starts; starts allowed once it clears.
// - Inhibit-on-voltage-fault setting blocks starts whenever any fault exists.
// - Undervoltage when lowest phase falls below level; levels 10-100, default 90.
// - Undervoltage only while running; trip, startup and warning delays.
// - Low-voltage start inhibit blocks starts below the inhibit level.
// - Overvoltage when highest phase exceeds level; levels 90-150, default 110.
// - Overvoltage only while running, with trip and warning delays.
// - Unbalance when percentage exceeds level; levels 1-20, default 6.
// - Unbalance evaluated whenever energized, with trip and warning delays.
// - Unbalance start inhibit blocks starts above the inhibit level.
// - Phase loss trips below fixed 70 percent after fixed 2 seconds.
// - Fault when measured phase sequence differs from expected sequence.
// - Sequence check always active, no delay; 0 off, 1 ABC, 2 ACB.
// - Power factor deviation trips beyond low or high signed levels.
// - Power factor deviation only while running, trip and warning delays.
`timescale 1ns/1ps

module svp_protect #(
  parameter int TICK_CYC = svp_pkg::TICK_CYCLES
) (
  input wire logic clk_sys, // 40 MHz system clock
  input wire logic resetn, // asynchronous reset, active low
  input wire logic voltage_option, // voltage sensing hardware fitted
  input wire logic motor_energized, // supply applied to the motor
  input wire logic motor_running, // motor in the running state
  input wire logic start_req, // one-cycle start request
  input wire logic [15:0] v_min_pct, // lowest phase voltage, % nominal
  input wire logic [15:0] v_max_pct, // highest phase voltage, % nominal
  input wire logic [15:0] v_unbal_pct, // voltage unbalance, %
  input wire logic [15:0] v_avg_volts, // average voltage, V RMS
  input wire logic [15:0] i_avg_pct, // average current, % full_load_current
  input wire logic [15:0] pf_dev, // signed power_factor deviation
  input wire logic [1:0] seq_meas, // measured sequence, 1 ABC, 2 ACB
  input wire logic [15:0] reg_addr, // register word address
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic [15:0] reg_wdata, // write data
  output logic [15:0] reg_rdata, // read data, valid with reg_ack
  output logic reg_ack, // access done, one cycle
  output logic reg_err, // access hit no register
  output logic trip, // latched motor trip
  output logic warning, // warning level
  output logic start_permit, // starts currently allowed
  output logic start_accept, // start request granted, one cycle
  output logic start_refused // start request refused, one cycle
);
  import svp_pkg::*;

  function automatic logic [19:0] tenths(input logic [15:0] s);
    tenths = 20'({s, 3'h0}) + 20'({s, 1'h0});
  endfunction : tenths

  // Offsets are sparse, so the lookup compares against every entry; the
  // result carries a hit flag in its top bit and the index below it.
  function automatic logic [5:0] find_reg(input logic [15:0] a);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 0; i < NREG; i++)
    begin
      if (a == REG_OFF[i])
        r = {1'b1, 5'(i)};
    end
    find_reg = r;
  endfunction : find_reg

  logic [15:0] cfg_reg [NREG];
  logic [15:0] reg_rdata_reg;
  logic reg_ack_reg;
  logic reg_err_reg;
  logic trip_reg;
  logic warn_reg;
  logic [15:0] trip_code_reg;
  logic [15:0] warn_code_reg;
  logic permit_reg;
  logic accept_reg;
  logic refused_reg;
  logic [31:0] tick_cnt_reg;
  logic tick_reg;
  logic [19:0] run_cnt_reg;

  // Register port decode. Writes to the status and code words other than
  // the trip clear are dropped without an error, since those words exist.
  wire logic [5:0] hit_idx = find_reg(reg_addr);
  wire logic cfg_hit = hit_idx[5];
  wire logic [4:0] cfg_idx = hit_idx[4:0];
  wire logic st_hit = (reg_addr == OFF_STATUS);
  wire logic tc_hit = (reg_addr == OFF_TRIP_CODE);
  wire logic wc_hit = (reg_addr == OFF_WARN_CODE);
  wire logic any_hit = cfg_hit | st_hit | tc_hit | wc_hit;
  wire logic clear_trip = reg_wr & st_hit & reg_wdata[ST_TRIP];

  // Per-protection condition, activity, and timer targets.
  logic [NPROT-1:0] cond_trip;
  logic [NPROT-1:0] cond_warn;
  logic [NPROT-1:0] active;
  logic [NPROT-1:0] has_warn;
  logic [NPROT-1:0] trip_due;
  logic [NPROT-1:0] warn_due;
  logic [19:0] trip_tgt [NPROT];
  logic [15:0] code_of [NPROT];

  wire logic [5:0] trip_en = cfg_reg[IX_TRIP_EN][5:0];
  wire logic [5:0] warn_en = cfg_reg[IX_WARN_EN][5:0];
  wire logic [15:0] inh_cfg = cfg_reg[IX_INH_CFG];
  wire logic [1:0] seq_sel = cfg_reg[IX_SEQ][1:0];
  wire logic [19:0] warn_tgt = tenths(cfg_reg[IX_WARN_DLY]);
  wire logic [19:0] start_tgt = tenths(cfg_reg[IX_UV_SDLY]);
  wire logic in_startup = run_cnt_reg < start_tgt;
  wire logic pf_valid = (v_avg_volts > PF_MIN_VAVG_V) &
    (i_avg_pct > PF_MIN_IAVG_PCT);
  wire logic signed [15:0] pf_s = pf_dev;

  assign cond_trip[P_UV] = v_min_pct < cfg_reg[IX_UV_TRIP];
  assign cond_warn[P_UV] = v_min_pct < cfg_reg[IX_UV_WARN];
  assign cond_trip[P_OV] = v_max_pct > cfg_reg[IX_OV_TRIP];
  assign cond_warn[P_OV] = v_max_pct > cfg_reg[IX_OV_WARN];
  assign cond_trip[P_UNB] = v_unbal_pct > cfg_reg[IX_UNB_TRIP];
  assign cond_warn[P_UNB] = v_unbal_pct > cfg_reg[IX_UNB_WARN];
  assign cond_trip[P_PHL] = v_min_pct < PHL_LEVEL_PCT;
  assign cond_warn[P_PHL] = 1'b0;
  assign cond_trip[P_SEQ] = (seq_sel != SEQ_OFF) &
    (seq_meas != seq_sel);
  assign cond_warn[P_SEQ] = 1'b0;
  assign cond_trip[P_PF] = pf_valid &
    ((pf_s < $signed(cfg_reg[IX_PFL_TRIP])) |
     (pf_s > $signed(cfg_reg[IX_PFH_TRIP])));
  assign cond_warn[P_PF] = pf_valid &
    ((pf_s < $signed(cfg_reg[IX_PFL_WARN])) |
     (pf_s > $signed(cfg_reg[IX_PFH_WARN])));

  // Motor state gating.
  assign active[P_UV] = voltage_option & motor_running;
  assign active[P_OV] = voltage_option & motor_running;
  assign active[P_UNB] = voltage_option & motor_energized;
  assign active[P_PHL] = voltage_option & motor_energized;
  assign active[P_SEQ] = voltage_option;
  assign active[P_PF] = voltage_option & motor_running;
  assign has_warn = 6'b100111;

  // The startup delay replaces the normal delay until the motor has run
  // for that long, so inrush dips do not trip a fresh start.
  assign trip_tgt[P_UV] = in_startup ? start_tgt :
    tenths(cfg_reg[IX_UV_DLY]);
  assign trip_tgt[P_OV] = tenths(cfg_reg[IX_OV_DLY]);
  assign trip_tgt[P_UNB] = tenths(cfg_reg[IX_UNB_DLY]);
  // Phase loss keeps its fixed delay; its level and delay registers only
  // store what software writes.
  assign trip_tgt[P_PHL] = tenths(PHL_DELAY_S);
  assign trip_tgt[P_SEQ] = 20'h00000;
  assign trip_tgt[P_PF] = tenths(cfg_reg[IX_PF_DLY]);

  assign code_of[P_UV] = CODE_UV;
  assign code_of[P_OV] = CODE_OV;
  assign code_of[P_UNB] = CODE_UNB;
  assign code_of[P_PHL] = CODE_PHL;
  assign code_of[P_SEQ] = CODE_SEQ;
  assign code_of[P_PF] = CODE_PF;

  // A timer holds at its target rather than wrapping, so a fault that
  // stays present keeps its output asserted.
  genvar g;
  for (g = 0; g < NPROT; g++)
  begin : g_prot
    logic [19:0] tcnt_reg;
    logic [19:0] wcnt_reg;
    wire logic t_run = active[g] & cond_trip[g];
    wire logic w_run = active[g] & cond_warn[g] & has_warn[g];

    always_ff @(posedge clk_sys or negedge resetn)
    begin
      if (!resetn)
        tcnt_reg <= 20'h00000;
      else if (!t_run)
        tcnt_reg <= 20'h00000;
      else if (tick_reg && tcnt_reg < trip_tgt[g])
        tcnt_reg <= tcnt_reg + 20'h00001;
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
      if (!resetn)
        wcnt_reg <= 20'h00000;
      else if (!w_run)
        wcnt_reg <= 20'h00000;
      else if (tick_reg && wcnt_reg < warn_tgt)
        wcnt_reg <= wcnt_reg + 20'h00001;
    end

    assign trip_due[g] = t_run & (tcnt_reg >= trip_tgt[g]) & trip_en[g];
    assign warn_due[g] = w_run & (wcnt_reg >= warn_tgt) & warn_en[g];
  end

  // Lowest-index protection that is newly firing names the fault.
  logic [15:0] new_trip_code;
  logic [15:0] new_warn_code;
  always_comb
  begin
    new_trip_code = 16'h0000;
    new_warn_code = 16'h0000;
    for (int i = NPROT - 1; i >= 0; i--)
    begin
      if (trip_due[i])
        new_trip_code = code_of[i];
      if (warn_due[i])
        new_warn_code = code_of[i];
    end
  end

  wire logic any_trip = |trip_due;
  wire logic any_warn = |warn_due;
  // Start gating uses the raw conditions, free of motor state and delay,
  // because a stopped motor would otherwise never show the fault.
  wire logic [5:0] cond_live = cond_trip & {6{voltage_option}};
  wire logic inhibit = (|(cond_live & trip_en)) |
    (inh_cfg[INH_ANY_FAULT] & (|cond_live)) |
    (voltage_option & inh_cfg[INH_LOW_VOLT] &
     (v_min_pct < cfg_reg[IX_UV_INH])) |
    (voltage_option & inh_cfg[INH_UNBAL] &
     (v_unbal_pct > cfg_reg[IX_UNB_INH]));

  // Tenth-second tick shared by every timer.
  // The tick runs free, so a delay may end up to one tick sooner than
  // set; a per-fault phase reset would cost a counter per protection.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      tick_cnt_reg <= 32'h00000000;
      tick_reg <= 1'b0;
    end
    else if (tick_cnt_reg >= 32'(TICK_CYC - 1))
    begin
      tick_cnt_reg <= 32'h00000000;
      tick_reg <= 1'b1;
    end
    else
    begin
      tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
      tick_reg <= 1'b0;
    end
  end

  // Time since the motor entered running, saturating.
  // It only selects the undervoltage startup delay.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      run_cnt_reg <= 20'h00000;
    else if (!motor_running)
      run_cnt_reg <= 20'h00000;
    else if (tick_reg && run_cnt_reg != 20'hfffff)
      run_cnt_reg <= run_cnt_reg + 20'h00001;
  end

  // Settings registers.
  // No range check is made; software must keep each setting in range.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < NREG; i++)
        cfg_reg[i] <= REG_RST[i];
    end
    else if (reg_wr && cfg_hit)
      cfg_reg[cfg_idx] <= reg_wdata;
  end

  // Trip latches until software clears it; a new trip in the clearing
  // cycle wins so it is never lost.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      trip_reg <= 1'b0;
      trip_code_reg <= 16'h0000;
    end
    else if (any_trip && !trip_reg)
    begin
      trip_reg <= 1'b1;
      trip_code_reg <= new_trip_code;
    end
    else if (clear_trip && !any_trip)
      trip_reg <= 1'b0;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      warn_reg <= 1'b0;
      warn_code_reg <= 16'h0000;
    end
    else
    begin
      // Not latched: the warning drops once no warning is due.
      warn_reg <= any_warn;
      if (any_warn && !warn_reg)
        warn_code_reg <= new_warn_code;
    end
  end

  // Start gating follows the live condition, so starts return at once.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      permit_reg <= 1'b0;
      accept_reg <= 1'b0;
      refused_reg <= 1'b0;
    end
    else
    begin
      permit_reg <= !inhibit;
      accept_reg <= start_req & !inhibit;
      refused_reg <= start_req & inhibit;
    end
  end

  // Read mux and access answer.
  // Read data is forced to zero outside an answer so the bus idles clean.
  logic [15:0] rd_mux;
  always_comb
  begin
    rd_mux = 16'h0000;
    if (cfg_hit)
      rd_mux = cfg_reg[cfg_idx];
    else if (st_hit)
    begin
      rd_mux[ST_TRIP] = trip_reg;
      rd_mux[ST_WARN] = warn_reg;
      rd_mux[ST_COND +: NPROT] = cond_live;
      rd_mux[ST_VOPT] = voltage_option;
    end
    else if (tc_hit)
      rd_mux = trip_code_reg;
    else if (wc_hit)
      rd_mux = warn_code_reg;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      reg_rdata_reg <= 16'h0000;
      reg_ack_reg <= 1'b0;
      reg_err_reg <= 1'b0;
    end
    else
    begin
      reg_rdata_reg <= reg_rd ? rd_mux : 16'h0000;
      reg_ack_reg <= reg_rd | reg_wr;
      reg_err_reg <= (reg_rd | reg_wr) & !any_hit;
    end
  end

  assign reg_rdata = reg_rdata_reg;
  assign reg_ack = reg_ack_reg;
  assign reg_err = reg_err_reg;
  assign trip = trip_reg;
  assign warning = warn_reg;
  assign start_permit = permit_reg;
  assign start_accept = accept_reg;
  assign start_refused = refused_reg;

endmodule : svp_protect

//--- src/svp_pkg.sv
/*
  Constants for the supply voltage protection block: register offsets,
  reset values, protection indices, fault codes and timing.
  Assumes a 40 MHz system clock and percent-scaled measurements.
*/
package svp_pkg;

  localparam int NREG = 24;
  localparam int NPROT = 6;

  // Protection slots; the lower index wins when two fire together.
  localparam int P_UV = 0;
  localparam int P_OV = 1;
  localparam int P_UNB = 2;
  localparam int P_PHL = 3;
  localparam int P_SEQ = 4;
  localparam int P_PF = 5;

  localparam logic [15:0] CODE_UV = 16'h0001;
  localparam logic [15:0] CODE_OV = 16'h0002;
  localparam logic [15:0] CODE_UNB = 16'h000b;
  localparam logic [15:0] CODE_PHL = 16'h000b;
  localparam logic [15:0] CODE_SEQ = 16'h0015;
  localparam logic [15:0] CODE_PF = 16'h0009;

  // Settings register indices.
  localparam int IX_SEQ = 0;
  localparam int IX_OV_TRIP = 1;
  localparam int IX_OV_WARN = 2;
  localparam int IX_OV_DLY = 3;
  localparam int IX_UV_TRIP = 4;
  localparam int IX_UV_WARN = 5;
  localparam int IX_UV_SDLY = 6;
  localparam int IX_UV_DLY = 7;
  localparam int IX_PHL_LVL = 8;
  localparam int IX_PHL_DLY = 9;
  localparam int IX_UNB_TRIP = 10;
  localparam int IX_UNB_WARN = 11;
  localparam int IX_UNB_DLY = 12;
  localparam int IX_PFH_TRIP = 13;
  localparam int IX_PFL_TRIP = 14;
  localparam int IX_PFH_WARN = 15;
  localparam int IX_PFL_WARN = 16;
  localparam int IX_PF_DLY = 17;
  localparam int IX_WARN_DLY = 18;
  localparam int IX_TRIP_EN = 19;
  localparam int IX_WARN_EN = 20;
  localparam int IX_INH_CFG = 21;
  localparam int IX_UV_INH = 22;
  localparam int IX_UNB_INH = 23;

  localparam logic [15:0] REG_OFF [NREG] = '{
    16'h0400, 16'h0401, 16'h0402, 16'h0403, 16'h0404, 16'h0405,
    16'h0406, 16'h0407, 16'h0411, 16'h0412, 16'h0413, 16'h0414,
    16'h0415, 16'h041f, 16'h0420, 16'h0421, 16'h0422, 16'h0423,
    16'h0437, 16'h0440, 16'h0441, 16'h0442, 16'h0443, 16'h0444};

  localparam logic [15:0] REG_RST [NREG] = '{
    16'h0001, 16'h006e, 16'h006e, 16'h0014, 16'h005a, 16'h005a,
    16'h0014, 16'h0014, 16'h0046, 16'h0002, 16'h0006, 16'h0006,
    16'h0014, 16'h2710, 16'h0000, 16'h2710, 16'h0000, 16'h0014,
    16'h0002, 16'h003f, 16'h000f, 16'h0000, 16'h005a, 16'h0006};

  // Read-only status words and the trip clear.
  localparam logic [15:0] OFF_STATUS = 16'h0445;
  localparam logic [15:0] OFF_TRIP_CODE = 16'h0446;
  localparam logic [15:0] OFF_WARN_CODE = 16'h0447;

  // Bits of the inhibit configuration register and of the status word.
  localparam int INH_ANY_FAULT = 0;
  localparam int INH_LOW_VOLT = 1;
  localparam int INH_UNBAL = 2;
  localparam int ST_TRIP = 0;
  localparam int ST_WARN = 1;
  localparam int ST_COND = 8;
  localparam int ST_VOPT = 15;

  localparam logic [1:0] SEQ_OFF = 2'h0;
  localparam logic [15:0] PHL_LEVEL_PCT = 16'h0046;
  localparam logic [15:0] PHL_DELAY_S = 16'h0002;
  localparam logic [15:0] PF_MIN_VAVG_V = 16'h0028;
  localparam logic [15:0] PF_MIN_IAVG_PCT = 16'h0032;

  // Timers count in tenths of a second.
  localparam int CLK_HZ = 40000000;
  localparam int TICK_MS = 100;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

endpackage : svp_pkg

//--- test/svp_protect_props.sv
/*
  Port-level checker for svp_protect: register answers, start answers
  and the trip and warning outputs.
  Assumes it is bound to the design's top module by the bind below.
*/
`timescale 1ns/1ps
module svp_protect_props (
  input wire logic clk_sys, // system clock
  input wire logic resetn, // reset, active low
  input wire logic voltage_option, // sensing option fitted
  input wire logic start_req, // start request
  input wire logic [15:0] reg_addr, // word address
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic [15:0] reg_wdata, // write data
  input wire logic [15:0] reg_rdata, // read data
  input wire logic reg_ack, // access done
  input wire logic reg_err, // unmapped access
  input wire logic trip, // latched trip
  input wire logic warning, // warning level
  input wire logic start_accept, // start granted
  input wire logic start_refused // start refused
);
  import svp_pkg::*;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  sequence s_reg_req;
    reg_wr || reg_rd;
  endsequence
  sequence s_start_answer;
    start_accept ^ start_refused;
  endsequence

  chk_ack_follows: assert property (s_reg_req |=> reg_ack)
    else $error("register access not answered next cycle");
  chk_ack_cause: assert property (reg_ack |-> $past(reg_wr || reg_rd))
    else $error("register answer without access");
  chk_err_ack: assert property (reg_err |-> reg_ack)
    else $error("error flag outside an answer");
  chk_rdata_idle: assert property (!reg_ack |-> reg_rdata == 16'h0)
    else $error("read data not zero outside an answer");
  chk_start_answer: assert property (start_req |=> s_start_answer)
    else $error("start request without exactly one answer");
  chk_answer_cause: assert property ((start_accept || start_refused)
    |-> $past(start_req))
    else $error("start answer without request");
  chk_trip_option: assert property ($rose(trip)
    |-> $past(voltage_option))
    else $error("trip without voltage sensing option");
  chk_warn_option: assert property ($rose(warning)
    |-> $past(voltage_option))
    else $error("warning without voltage sensing option");
  chk_trip_hold: assert property ($fell(trip)
    |-> $past(reg_wr && reg_addr == OFF_STATUS && reg_wdata[ST_TRIP]))
    else $error("trip dropped without a clear write");
endmodule : svp_protect_props

bind svp_protect svp_protect_props i_props (.clk_sys, .resetn,
  .voltage_option, .start_req, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
  .reg_rdata, .reg_ack, .reg_err, .trip, .warning, .start_accept,
  .start_refused);

//--- test/svp_front.sv
/*
  Behavioural measurement front end and motor state source.
  Assumes the bench calls put from its main sequence.
*/
`timescale 1ns/1ps
module svp_front (
  input wire logic clk_sys, // system clock
  output logic voltage_option, // sensing option fitted
  output logic motor_energized, // supply on motor
  output logic motor_running, // running state
  output logic [15:0] v_min_pct, // lowest phase, %
  output logic [15:0] v_max_pct, // highest phase, %
  output logic [15:0] v_unbal_pct, // unbalance, %
  output logic [15:0] v_avg_volts, // average volts
  output logic [15:0] i_avg_pct, // average current, %
  output logic [15:0] pf_dev, // power_factor deviation
  output logic [1:0] seq_meas // measured sequence
);
  initial
  begin
    {voltage_option, motor_energized, motor_running} = 3'h0;
    {v_min_pct, v_max_pct, v_unbal_pct, v_avg_volts} = 64'h0;
    {i_avg_pct, pf_dev, seq_meas} = 34'h0;
  end

  // Readings change on the falling edge so the design never sees a race.
  task automatic put(input logic [2:0] st, input logic [15:0] vmin, vmax,
    unb, iavg, pf, input logic [1:0] seq);
    @(negedge clk_sys);
    {voltage_option, motor_energized, motor_running} = st;
    v_min_pct = vmin;
    v_max_pct = vmax;
    v_unbal_pct = unb;
    v_avg_volts = 16'h32;
    i_avg_pct = iavg;
    pf_dev = pf;
    seq_meas = seq;
  endtask : put

  // Overrides the average voltage until the next put.
  task automatic set_vavg(input logic [15:0] v);
    v_avg_volts = v;
  endtask : set_vavg
endmodule : svp_front

//--- test/testbench.sv
/*
  Self-checking bench for svp_protect with a four-cycle tick.
  Assumes the checker binds itself and svp_front supplies readings.
*/
`timescale 1ns/1ps
module testbench;
  import svp_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic start_req = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_addr = 16'h0;
  logic [15:0] reg_wdata = 16'h0;
  logic voltage_option, motor_energized, motor_running;
  logic [15:0] v_min_pct, v_max_pct, v_unbal_pct, v_avg_volts;
  logic [15:0] i_avg_pct, pf_dev, reg_rdata;
  logic [1:0] seq_meas;
  logic reg_ack, reg_err, trip, warning;
  logic start_permit, start_accept, start_refused;
  int n_mismatch = 0;
  int comparisons = 0;
  int seed = 32'h97ce1e97;
  logic [17:0] q_reg[$];
  logic q_st[$];

  always #12.5 clk_sys = ~clk_sys;

  svp_front i_front (.clk_sys, .voltage_option, .motor_energized,
    .motor_running, .v_min_pct, .v_max_pct, .v_unbal_pct, .v_avg_volts,
    .i_avg_pct, .pf_dev, .seq_meas);

  // One second is 40 cycles with this tick.
  svp_protect #(.TICK_CYC(4)) i_dut (.clk_sys, .resetn, .voltage_option,
    .motor_energized, .motor_running, .start_req, .v_min_pct, .v_max_pct,
    .v_unbal_pct, .v_avg_volts, .i_avg_pct, .pf_dev, .seq_meas, .reg_addr,
    .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_ack, .reg_err, .trip,
    .warning, .start_permit, .start_accept, .start_refused);

  task automatic check(input logic ok, input string what);
    comparisons++;
    if (ok !== 1'b1)
    begin
      n_mismatch++;
      $display("ERROR %0t %s", $time, what);
    end
  endtask : check

  task automatic summarize();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  always @(posedge clk_sys)
  begin
    logic [17:0] e;
    #1;
    if (reg_ack === 1'b1)
    begin
      e = (q_reg.size() > 0) ? q_reg.pop_front() : 18'h3ffff;
      check(reg_err === e[16] && (!e[17] || reg_rdata === e[15:0]),
        "register answer");
    end
    if ((start_accept | start_refused) === 1'b1)
    begin
      e[0] = (q_st.size() > 0) ? q_st.pop_front() : 1'bx;
      check(start_accept === e[0] && start_refused === !e[0], "start answer");
    end
  end

  task automatic acc(input logic wr, input logic [15:0] a, d,
    input logic [17:0] e);
    @(negedge clk_sys);
    reg_wr = wr;
    reg_rd = !wr;
    reg_addr = a;
    reg_wdata = d;
    q_reg.push_back(e);
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  endtask : acc

  task automatic wr(input logic [15:0] a, d);
    acc(1'b1, a, d, 18'h0);
  endtask : wr

  task automatic rd(input logic [15:0] a, e);
    acc(1'b0, a, 16'h0, {2'b10, e});
  endtask : rd

  // Two idle cycles first, so the inhibit has seen the latest readings.
  task automatic start(input logic ok);
    repeat (2) @(negedge clk_sys);
    check(start_permit === ok, "start permit");
    start_req = 1'b1;
    q_st.push_back(ok);
    @(negedge clk_sys);
    start_req = 1'b0;
  endtask : start

  task automatic wait_for(input logic w, input int lo, hi);
    int n = 0;
    while ((w ? warning : trip) !== 1'b1 && n <= hi)
    begin
      @(negedge clk_sys);
      n++;
    end
    check(n >= lo && n <= hi, "trip or warning timing");
    if (n > hi)
      summarize();
  endtask : wait_for

  task automatic quiet(input int n);
    repeat (n) @(negedge clk_sys);
    check(trip === 1'b0, "unexpected trip");
  endtask : quiet

  task automatic healthy(input logic [2:0] st);
    i_front.put(st, 16'h5f, 16'h5f + 16'($random(seed) & 15), 16'h2,
      16'h3c, 16'h64, 2'h1);
  endtask : healthy

  task automatic fault(input logic [15:0] vmin, vmax, unb, pf,
    input logic [2:0] st, input logic [15:0] code, input int lo, hi);
    i_front.put(st, vmin, vmax, unb, 16'h3c, pf, 2'h1);
    wait_for(1'b0, lo, hi);
    rd(OFF_TRIP_CODE, code);
    healthy(3'h7);
    wr(OFF_STATUS, 16'h1);
    rd(OFF_STATUS, 16'h8000);
  endtask : fault

  initial
  begin
    logic [15:0] d;
    healthy(3'h7);
    repeat (16) @(negedge clk_sys);
    resetn = 1'b1;
    for (int i = 0; i < NREG; i++)
      rd(REG_OFF[i], REG_RST[i]);
    acc(1'b0, 16'h0410, 16'h0, 18'h30000);
    acc(1'b1, 16'h0410, 16'h1234, 18'h10000);
    d = 16'($random(seed));
    wr(16'h0411, d);
    rd(16'h0411, d);
    rd(OFF_STATUS, 16'h8000);
    for (int s = 0; s < 3; s++)
      for (int m = 1; m < 3; m++)
      begin
        // Reading first, so the new selection never meets a stale reading.
        i_front.put(3'h4, 16'h5f, 16'h64, 16'h2, 16'h3c, 16'h64, 2'(m));
        wr(16'h0400, 16'(s));
        repeat (3) @(negedge clk_sys);
        check(trip === (s != 0 && s != m), "sequence trip");
        start(s == 0 || s == m);
        wr(16'h0400, 16'h0);
        wr(OFF_STATUS, 16'h1);
      end
    rd(OFF_TRIP_CODE, CODE_SEQ);
    i_front.put(3'h3, 16'h50, 16'h6f, 16'h7, 16'h3c, 16'hfffb, 2'h2);
    wr(16'h0400, 16'h1);
    quiet(60);
    rd(OFF_STATUS, 16'h0000);
    start(1'b1);
    for (int i = 0; i < NREG; i++)
      if (i == IX_OV_DLY || i == IX_UV_SDLY || i == IX_UV_DLY ||
          i == IX_UNB_DLY || i == IX_PF_DLY || i == IX_WARN_DLY)
        wr(REG_OFF[i], 16'h1);
    healthy(3'h7);
    fault(16'h59, 16'h64, 16'h2, 16'h64, 3'h7, CODE_UV, 36, 48);
    fault(16'h5f, 16'h6f, 16'h2, 16'h64, 3'h7, CODE_OV, 36, 48);
    fault(16'h5f, 16'h64, 16'h7, 16'h64, 3'h6, CODE_UNB, 36, 48);
    fault(16'h45, 16'h64, 16'h2, 16'h64, 3'h6, CODE_PHL, 76, 88);
    fault(16'h5f, 16'h64, 16'h2, 16'hfffb, 3'h7, CODE_PF, 36, 48);
    fault(16'h5f, 16'h64, 16'h2, 16'h2711, 3'h7, CODE_PF, 36, 48);
    i_front.put(3'h7, 16'h5f, 16'h64, 16'h2, 16'h32, 16'hfffb, 2'h1);
    quiet(60);
    i_front.put(3'h7, 16'h5f, 16'h64, 16'h2, 16'h3c, 16'hfffb, 2'h1);
    i_front.set_vavg(16'h28);
    quiet(60);
    i_front.put(3'h7, 16'h50, 16'h64, 16'h2, 16'h3c, 16'h64, 2'h1);
    repeat (20) @(negedge clk_sys);
    healthy(3'h7);
    fault(16'h50, 16'h64, 16'h2, 16'h64, 3'h7, CODE_UV, 36, 48);
    wr(16'h0440, 16'h0);
    i_front.put(3'h7, 16'h50, 16'h64, 16'h2, 16'h3c, 16'h64, 2'h1);
    wait_for(1'b1, 36, 48);
    check(trip === 1'b0, "trip while disabled");
    rd(OFF_WARN_CODE, CODE_UV);
    start(1'b1);
    wr(16'h0442, 16'h2);
    start(1'b0);
    wr(16'h0442, 16'h1);
    start(1'b0);
    i_front.put(3'h7, 16'h5f, 16'h64, 16'h7, 16'h3c, 16'h64, 2'h1);
    start(1'b0);
    wr(16'h0442, 16'h4);
    start(1'b0);
    wr(16'h0444, 16'h8);
    start(1'b1);
    repeat (4) @(negedge clk_sys);
    check(q_reg.size() == 0 && q_st.size() == 0, "answers missing");
    summarize();
  end
endmodule : testbench
